// ---- design/olock_cfg.svh ----
`ifndef OLOCK_CFG_SVH
`define OLOCK_CFG_SVH

`define OLOCK_ADDR_W          24
`define OLOCK_SN_LOCK_OFS     24'h000100
`define OLOCK_LOW_A_OFS       24'h000112
`define OLOCK_LOW_B_OFS       24'h000113
`define OLOCK_HIGH_A_OFS      24'h000214
`define OLOCK_HIGH_B_OFS      24'h000215

`define OLOCK_SN_LOW_FIRST    24'h000102
`define OLOCK_SN_LOW_LAST     24'h000109
`define OLOCK_SN_HIGH_FIRST   24'h00010a
`define OLOCK_SN_HIGH_LAST    24'h000111
`define OLOCK_USER_LOW_FIRST  24'h000114
`define OLOCK_USER_LOW_LAST   24'h000213
`define OLOCK_USER_HIGH_FIRST 24'h000216
`define OLOCK_USER_HIGH_LAST  24'h0002ff

`define OLOCK_REGION_SHIFT    4
`define OLOCK_SN_LOW_IDX      6'h00
`define OLOCK_SN_HIGH_IDX     6'h01
`define OLOCK_USER_LOW_IDX    6'h02
`define OLOCK_USER_HIGH_IDX   6'h12

`define OLOCK_ERASED          8'hff
`define OLOCK_SN_FIXED        8'hfc
`define OLOCK_HIGH_B_FIXED    8'h80
`define OLOCK_NO_FIXED        8'h00

`endif

// ---- design/olock_pkg.sv ----
package olock_pkg;

    typedef enum logic [2:0] {
        OLOCK_SEL_NONE   = 3'b000,
        OLOCK_SEL_SN     = 3'b001,
        OLOCK_SEL_LOW_A  = 3'b010,
        OLOCK_SEL_LOW_B  = 3'b011,
        OLOCK_SEL_HIGH_A = 3'b100,
        OLOCK_SEL_HIGH_B = 3'b101
    } olock_sel_t;

    typedef logic [5:0] olock_region_t;
    typedef logic [2:0] olock_byte_idx_t;

endpackage : olock_pkg

// ---- design/olock_dec_if.sv ----
`timescale 1ns/100ps
interface olock_dec_if #(
    parameter int ADDR_W = 24
);
    logic [ADDR_W-1:0]       addr;
    olock_pkg::olock_sel_t    sel;
    logic                     hit;
    olock_pkg::olock_region_t region;

    modport req (
        output addr,
        input  sel,
        input  hit,
        input  region
    );

    modport dec (
        input  addr,
        output sel,
        output hit,
        output region
    );
endinterface : olock_dec_if

// ---- design/olock_region_dec.sv ----
`timescale 1ns/100ps
`include "olock_cfg.svh"
module olock_region_dec (
    olock_dec_if.dec d
);
    logic [`OLOCK_ADDR_W-1:0] low_ofs;
    logic [`OLOCK_ADDR_W-1:0] high_ofs;

    assign low_ofs  = d.addr - `OLOCK_USER_LOW_FIRST;
    assign high_ofs = d.addr - `OLOCK_USER_HIGH_FIRST;

    always_comb
    begin
        d.sel    = olock_pkg::OLOCK_SEL_NONE;
        d.hit    = 1'b0;
        d.region = `OLOCK_SN_LOW_IDX;
        unique case (d.addr)
            `OLOCK_SN_LOCK_OFS: d.sel = olock_pkg::OLOCK_SEL_SN;
            `OLOCK_LOW_A_OFS:   d.sel = olock_pkg::OLOCK_SEL_LOW_A;
            `OLOCK_LOW_B_OFS:   d.sel = olock_pkg::OLOCK_SEL_LOW_B;
            `OLOCK_HIGH_A_OFS:  d.sel = olock_pkg::OLOCK_SEL_HIGH_A;
            `OLOCK_HIGH_B_OFS:  d.sel = olock_pkg::OLOCK_SEL_HIGH_B;
            default:            d.sel = olock_pkg::OLOCK_SEL_NONE;
        endcase
        // Region data bytes; the last user region is short, so its range ends at the top
        if (d.addr >= `OLOCK_SN_LOW_FIRST && d.addr <= `OLOCK_SN_LOW_LAST)
        begin
            d.hit    = 1'b1;
            d.region = `OLOCK_SN_LOW_IDX;
        end
        else if (d.addr >= `OLOCK_SN_HIGH_FIRST && d.addr <= `OLOCK_SN_HIGH_LAST)
        begin
            d.hit    = 1'b1;
            d.region = `OLOCK_SN_HIGH_IDX;
        end
        else if (d.addr >= `OLOCK_USER_LOW_FIRST && d.addr <= `OLOCK_USER_LOW_LAST)
        begin
            d.hit    = 1'b1;
            d.region = `OLOCK_USER_LOW_IDX + {2'b00, low_ofs[`OLOCK_REGION_SHIFT+3:4]};
        end
        else if (d.addr >= `OLOCK_USER_HIGH_FIRST && d.addr <= `OLOCK_USER_HIGH_LAST)
        begin
            d.hit    = 1'b1;
            d.region = `OLOCK_USER_HIGH_IDX + {2'b00, high_ofs[`OLOCK_REGION_SHIFT+3:4]};
        end
    end
endmodule : olock_region_dec

// ---- design/olock_map.sv ----
// Notes on behaviour
// - Lock bits at fixed one-time addresses; programming one permanently locks its region.
// - Bit 0 of lock byte 0x100 locks the lower serial-number region.
// - Bit 1 of lock byte 0x100 locks the upper serial-number region.
// - Bits 2 to 7 of byte 0x100 cannot be programmed; such attempts ignored.
// - Bit 7 of byte 0x215 cannot be programmed; such attempts ignored.
// - Byte 0x214 bits 0 to 7 lock user regions 17 to 24.
// - A locked region refuses every further program; only reset clears a lock.
`timescale 1ns/100ps
`include "olock_cfg.svh"
module olock_map #(
    parameter int ADDR_W  = `OLOCK_ADDR_W,
    parameter int REGIONS = 33
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              prog_valid,
    input  wire logic [ADDR_W-1:0] prog_addr,
    input  wire logic [7:0]        prog_data,
    input  wire logic              rd_valid,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic                   prog_lock_done,
    output logic                   prog_grant,
    output logic                   prog_refuse,
    output logic                   prog_ignore,
    output logic [ADDR_W-1:0]      grant_addr,
    output logic [7:0]             grant_data,
    output logic                   rd_data_valid,
    output logic                   rd_lock_hit,
    output logic [7:0]             rd_data,
    output logic [REGIONS-1:0]     region_locked
);
    // Programmed lock bits read 0, as in the rest of the one-time space
    // Entries: serial_number_lock_byte, user_lock_byte_low_a/_b, user_lock_byte_high_a/_b
    logic [7:0]          lock_reg [0:4];
    logic [7:0]          lock_next [0:4];
    logic                lock_done_reg;
    logic                lock_done_next;
    logic                grant_reg;
    logic                grant_next;
    logic                refuse_reg;
    logic                refuse_next;
    logic                ignore_reg;
    logic                ignore_next;
    logic [ADDR_W-1:0]   gaddr_reg;
    logic [ADDR_W-1:0]   gaddr_next;
    logic [7:0]          gdata_reg;
    logic [7:0]          gdata_next;
    logic                rvalid_reg;
    logic                rvalid_next;
    logic                rhit_reg;
    logic                rhit_next;
    logic [7:0]          rdata_reg;
    logic [7:0]          rdata_next;
    olock_pkg::olock_byte_idx_t pidx;
    olock_pkg::olock_byte_idx_t ridx;

    olock_dec_if #(.ADDR_W(ADDR_W)) pd ();
    olock_dec_if #(.ADDR_W(ADDR_W)) rd ();

    assign pd.addr = prog_addr;
    assign rd.addr = rd_addr;

    olock_region_dec u_prog_dec (
        .d (pd)
    );

    olock_region_dec u_rd_dec (
        .d (rd)
    );

    function automatic olock_pkg::olock_byte_idx_t byte_idx(input olock_pkg::olock_sel_t s);
        byte_idx = 3'(s) - 3'h1;
    endfunction : byte_idx

    function automatic logic [7:0] fixed_mask(input olock_pkg::olock_sel_t s);
        unique case (s)
            olock_pkg::OLOCK_SEL_SN:     fixed_mask = `OLOCK_SN_FIXED;
            olock_pkg::OLOCK_SEL_HIGH_B: fixed_mask = `OLOCK_HIGH_B_FIXED;
            default:                     fixed_mask = `OLOCK_NO_FIXED;
        endcase
    endfunction : fixed_mask

    assign pidx = byte_idx(pd.sel);
    assign ridx = byte_idx(rd.sel);

    // Serial pair first, then user regions 1 to 31 in ascending order
    assign region_locked = ~{lock_reg[4][6:0], lock_reg[3], lock_reg[2], lock_reg[1],
                             lock_reg[0][1:0]};

    always_comb
    begin
        for (int i = 0; i < 5; i++)
        begin
            lock_next[i] = lock_reg[i];
        end
        lock_done_next = 1'b0;
        grant_next     = 1'b0;
        refuse_next    = 1'b0;
        ignore_next    = 1'b0;
        gaddr_next     = gaddr_reg;
        gdata_next     = gdata_reg;
        if (prog_valid)
        begin
            if (pd.sel != olock_pkg::OLOCK_SEL_NONE)
            begin
                // Bits only ever go 1 to 0, so no program can undo a lock
                lock_next[pidx] = lock_reg[pidx] & (prog_data | fixed_mask(pd.sel));
                lock_done_next  = 1'b1;
            end
            else if (pd.hit && region_locked[pd.region])
            begin
                refuse_next = 1'b1;
            end
            else if (pd.hit)
            begin
                grant_next = 1'b1;
                gaddr_next = prog_addr;
                gdata_next = prog_data;
            end
            else
            begin
                ignore_next = 1'b1;
            end
        end
    end

    always_comb
    begin
        rvalid_next = rd_valid;
        rhit_next   = rhit_reg;
        rdata_next  = rdata_reg;
        if (rd_valid)
        begin
            rhit_next  = (rd.sel != olock_pkg::OLOCK_SEL_NONE);
            rdata_next = rhit_next ? lock_reg[ridx] : `OLOCK_ERASED;
        end
    end

    // Reset stands for power-up of a fresh part; real retention lives in the cell array
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 5; i++)
            begin
                lock_reg[i] <= `OLOCK_ERASED;
            end
            lock_done_reg <= 1'b0;
            grant_reg     <= 1'b0;
            refuse_reg    <= 1'b0;
            ignore_reg    <= 1'b0;
            gaddr_reg     <= '0;
            gdata_reg     <= `OLOCK_ERASED;
            rvalid_reg    <= 1'b0;
            rhit_reg      <= 1'b0;
            rdata_reg     <= `OLOCK_ERASED;
        end
        else
        begin
            for (int i = 0; i < 5; i++)
            begin
                lock_reg[i] <= lock_next[i];
            end
            lock_done_reg <= lock_done_next;
            grant_reg     <= grant_next;
            refuse_reg    <= refuse_next;
            ignore_reg    <= ignore_next;
            gaddr_reg     <= gaddr_next;
            gdata_reg     <= gdata_next;
            rvalid_reg    <= rvalid_next;
            rhit_reg      <= rhit_next;
            rdata_reg     <= rdata_next;
        end
    end

    assign prog_lock_done = lock_done_reg;
    assign prog_grant     = grant_reg;
    assign prog_refuse    = refuse_reg;
    assign prog_ignore    = ignore_reg;
    assign grant_addr     = gaddr_reg;
    assign grant_data     = gdata_reg;
    assign rd_data_valid  = rvalid_reg;
    assign rd_lock_hit    = rhit_reg;
    assign rd_data        = rdata_reg;

    a_lock_never_clears: assert property (
        @(posedge clk) disable iff (!nrst)
        (($past(region_locked) & ~region_locked) == '0))
        else $error("a region lock was cleared");

    a_locked_refused: assert property (
        @(posedge clk) disable iff (!nrst)
        (prog_valid && pd.sel == olock_pkg::OLOCK_SEL_NONE && pd.hit
         && region_locked[pd.region])
        |=> (prog_refuse && !prog_grant))
        else $error("program to a locked region was not refused");

    a_open_granted: assert property (
        @(posedge clk) disable iff (!nrst)
        (prog_valid && pd.sel == olock_pkg::OLOCK_SEL_NONE && pd.hit
         && !region_locked[pd.region])
        |=> (prog_grant && grant_addr == $past(prog_addr) && grant_data == $past(prog_data)))
        else $error("program to an open region was not passed on");

    a_outside_ignored: assert property (
        @(posedge clk) disable iff (!nrst)
        (prog_valid && pd.sel == olock_pkg::OLOCK_SEL_NONE && !pd.hit)
        |=> (prog_ignore && !prog_grant && !prog_refuse))
        else $error("program outside the regions was not ignored");

    a_sn_fixed_bits: assert property (
        @(posedge clk) disable iff (!nrst)
        (lock_reg[0][7:2] == 6'h3f))
        else $error("fixed serial lock bits changed");

    a_high_b_fixed: assert property (
        @(posedge clk) disable iff (!nrst)
        (lock_reg[4][7] == 1'b1))
        else $error("fixed top lock bit changed");

    a_sn_low_lock: assert property (
        @(posedge clk) disable iff (!nrst)
        (prog_valid && prog_addr == `OLOCK_SN_LOCK_OFS && !prog_data[0])
        |=> region_locked[0] ##1 region_locked[0])
        else $error("lower serial region not locked by bit 0");

    a_sn_high_lock: assert property (
        @(posedge clk) disable iff (!nrst)
        (prog_valid && prog_addr == `OLOCK_SN_LOCK_OFS && !prog_data[1])
        |=> region_locked[1])
        else $error("upper serial region not locked by bit 1");

    a_high_a_order: assert property (
        @(posedge clk) disable iff (!nrst)
        (prog_valid && prog_addr == `OLOCK_HIGH_A_OFS && prog_data == 8'h7f
         && !region_locked[25])
        |=> (region_locked[25] && $stable(region_locked[24:18])))
        else $error("bit 7 of the high lock byte did not lock region 24 alone");

    a_user_low_map: assert property (
        @(posedge clk) disable iff (!nrst)
        (prog_valid && prog_addr == `OLOCK_LOW_A_OFS && !prog_data[0])
        |=> region_locked[2])
        else $error("region 1 not locked by its bit");

    a_user_top_map: assert property (
        @(posedge clk) disable iff (!nrst)
        (prog_valid && prog_addr == `OLOCK_HIGH_B_OFS && !prog_data[6])
        |=> region_locked[32])
        else $error("region 31 not locked by its bit");
endmodule : olock_map

// ---- verif/olock_host_model.sv ----
`timescale 1ns/100ps
module olock_host_model (
    input  wire logic        clk,
    output logic             prog_valid,
    output logic [23:0]      prog_addr,
    output logic [7:0]       prog_data,
    output logic             rd_valid,
    output logic [23:0]      rd_addr
);
    // Idle lines flip, so a stale value never passes for a request
    initial
    begin
        prog_valid = 1'b0;
        prog_addr  = 24'h000000;
        prog_data  = 8'hff;
        rd_valid   = 1'b0;
        rd_addr    = 24'h000000;
    end

    // One or two bytes per program, the second in the next cycle; region data may come before its lock
    task automatic prog(input logic [23:0] a0, input logic [7:0] d0, input logic two,
                        input logic [23:0] a1, input logic [7:0] d1);
        @(negedge clk);
        prog_valid = 1'b1;
        prog_addr  = a0;
        prog_data  = d0;
        if (two)
        begin
            @(negedge clk);
            prog_addr = a1;
            prog_data = d1;
        end
        @(negedge clk);
        prog_valid = 1'b0;
        prog_addr  = ~prog_addr;
        prog_data  = ~prog_data;
    endtask : prog

    task automatic rd(input logic [23:0] a);
        @(negedge clk);
        rd_valid = 1'b1;
        rd_addr  = a;
        @(negedge clk);
        rd_valid = 1'b0;
        rd_addr  = ~a;
    endtask : rd
endmodule : olock_host_model

// ---- verif/test_olock_map.sv ----
`timescale 1ns/100ps
`include "olock_cfg.svh"
module test_olock_map;
    localparam logic [3:0] DONE = 4'h8, GRANT = 4'h4, REFUSE = 4'h2, IGN = 4'h1;
    logic        clk;
    logic        nrst;
    logic        prog_valid, rd_valid;
    logic [23:0] prog_addr, rd_addr, grant_addr, first, last, la;
    logic [7:0]  prog_data, grant_data, rd_data;
    logic        prog_lock_done, prog_grant, prog_refuse, prog_ignore;
    logic        rd_data_valid, rd_lock_hit;
    logic [32:0] region_locked, exp_lock;
    int          fail_count;
    int          num_checks;
    int          k;

    olock_host_model i_host (.clk(clk), .prog_valid(prog_valid), .prog_addr(prog_addr),
        .prog_data(prog_data), .rd_valid(rd_valid), .rd_addr(rd_addr));

    olock_map i_dut (.clk(clk), .nrst(nrst), .prog_valid(prog_valid), .prog_addr(prog_addr),
        .prog_data(prog_data), .rd_valid(rd_valid), .rd_addr(rd_addr),
        .prog_lock_done(prog_lock_done), .prog_grant(prog_grant), .prog_refuse(prog_refuse),
        .prog_ignore(prog_ignore), .grant_addr(grant_addr), .grant_data(grant_data),
        .rd_data_valid(rd_data_valid), .rd_lock_hit(rd_lock_hit), .rd_data(rd_data),
        .region_locked(region_locked));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Checks the answer pulses, the granted pair and the lock vector
    task automatic wr(input logic [23:0] a, input logic [7:0] d, input logic [3:0] res);
        logic [4:0] pulses;
        i_host.prog(a, d, 1'b0, 24'h000000, 8'hff);
        // A read answer that lingered would show here, after an idle read port
        pulses = {prog_lock_done, prog_grant, prog_refuse, prog_ignore, rd_data_valid};
        chk(33'(pulses), 33'({res, 1'b0}));
        if (res === GRANT)
            chk(33'({grant_addr, grant_data}), 33'({a, d}));
        chk(region_locked, exp_lock);
    endtask : wr

    task automatic rdc(input logic [23:0] a, input logic [7:0] d, input logic hit);
        i_host.rd(a);
        chk(33'({rd_data_valid, rd_lock_hit, rd_data}), 33'({1'b1, hit, d}));
    endtask : rdc

    initial
    begin
        #20000;
        fail_count++;
        $display("Watchdog expired");
        conclude;
    end

    initial
    begin
        nrst = 1'b0;
        exp_lock = '0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        chk(region_locked, exp_lock);
        rdc(`OLOCK_SN_LOCK_OFS, `OLOCK_ERASED, 1'b1);
        rdc(24'h000101, 8'hff, 1'b0);
        wr(24'h000101, 8'h00, IGN);
        wr(24'h000000, 8'h00, IGN);
        wr(`OLOCK_SN_LOW_LAST, 8'h5a, GRANT);
        exp_lock[0] = 1'b1;
        // Lock then program the next cycle: the new lock must already bite
        i_host.prog(`OLOCK_SN_LOCK_OFS, 8'hfe, 1'b1, `OLOCK_SN_LOW_FIRST, 8'h00);
        chk(33'(prog_refuse), 33'h1);
        chk(region_locked, exp_lock);
        wr(`OLOCK_SN_HIGH_FIRST, 8'h33, GRANT);
        exp_lock[1] = 1'b1;
        wr(`OLOCK_SN_LOCK_OFS, 8'h00, DONE);
        wr(`OLOCK_SN_HIGH_LAST, 8'h00, REFUSE);
        rdc(`OLOCK_SN_LOCK_OFS, `OLOCK_SN_FIXED, 1'b1);
        wr(`OLOCK_SN_LOCK_OFS, 8'hff, DONE);
        for (k = 1; k <= 31; k++)
        begin
            first = (k < 17) ? `OLOCK_USER_LOW_FIRST + 24'(16 * (k - 1))
                             : `OLOCK_USER_HIGH_FIRST + 24'(16 * (k - 17));
            last = (k == 31) ? `OLOCK_USER_HIGH_LAST : first + 24'h00000f;
            la = (k < 9) ? `OLOCK_LOW_A_OFS : (k < 17) ? `OLOCK_LOW_B_OFS
               : (k < 25) ? `OLOCK_HIGH_A_OFS : `OLOCK_HIGH_B_OFS;
            wr(last, 8'h0f, GRANT);
            exp_lock[k + 1] = 1'b1;
            wr(la, 8'(~(8'h01 << ((k - 1) % 8))), DONE);
            wr(first, 8'h00, REFUSE);
        end
        wr(`OLOCK_HIGH_B_OFS, 8'h00, DONE);
        rdc(`OLOCK_HIGH_B_OFS, `OLOCK_HIGH_B_FIXED, 1'b1);
        rdc(`OLOCK_HIGH_A_OFS, 8'h00, 1'b1);
        rdc(`OLOCK_LOW_A_OFS, 8'h00, 1'b1);
        rdc(`OLOCK_LOW_B_OFS, 8'h00, 1'b1);
        conclude;
    end
endmodule : test_olock_map
